// >>> shared/slbc_defs.vh
// Register map, field positions and timing counts of the lane test block
`ifndef SLBC_DEFS_VH
`define SLBC_DEFS_VH

// Byte offsets of MAC instance 0; instances repeat every stride
`define SLBC_CTRL_OFF 18'h130C8
`define SLBC_L0_CNT0_OFF 18'h130CC
`define SLBC_L0_CNT1_OFF 18'h130D0
`define SLBC_LANE_STRIDE 18'h00008
`define SLBC_MAC_STRIDE 18'h00200
`define SLBC_ADR_W 18

// Reset values
`define SLBC_CTRL_RST 32'h00000000
`define SLBC_CNT_RST 32'h00000000

// Lane count and per-lane byte in the control word
`define SLBC_LANES 4
`define SLBC_LANE_BITS 8
// Positions inside a lane byte (bit 0 is the least significant)
`define SLBC_F_CLEAR 0
`define SLBC_F_FREEZE 1
`define SLBC_F_ALIGN 2
`define SLBC_F_START 3
`define SLBC_F_PAT_LO 4
`define SLBC_F_PAT_HI 6
`define SLBC_PAT_W 3

// Pattern select codes
`define SLBC_PAT_OFF 3'h0
`define SLBC_PAT_PRBS 3'h1
`define SLBC_PAT_LOOP 3'h2
`define SLBC_PAT_FIXED 3'h4

// Counter widths and the split of the group counter
`define SLBC_GRP_W 48
`define SLBC_ERR_W 16
`define SLBC_GRP_HI_W 16

// Alignment request length in clock cycles, and its reload value
`define SLBC_ALIGN_CYCLES 4
`define SLBC_ALIGN_RELOAD 3'h3

`endif

// >>> verilog/slbc_top.v
// Lane bit error rate test control and counters with a Wishbone slave
`timescale 1ns/1ps
`include "slbc_defs.vh"

// Function
// - Align bit pulses checker four cycles, reads zero
// - Freeze bit holds both lane counters still
// - Clear bit zeroes lane counters, self-clearing
// - One little-endian byte per lane, lane 0 lowest
// - Counter register 0 high half: group[47:32]
// - Counter register 0 low half: error count
// - Counter register 1 holds group count low
// - Writing zero to counter register clears it
// - Register block repeats per MAC, 0x200 apart
// - Pattern codes: off, PRBS, loopback, fixed
// - Start bit releases or resets the generator
module slbc_top #(
  parameter [1:0] MAC_INDEX = 2'h0
) (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [`SLBC_ADR_W-1:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire wb_ack_o,
  input wire [`SLBC_LANES-1:0] code_group_valid_i,
  input wire [`SLBC_LANES-1:0] code_group_error_i,
  output wire [`SLBC_LANES*`SLBC_PAT_W-1:0] pattern_sel_o,
  output wire [`SLBC_LANES-1:0] generator_release_o,
  output wire [`SLBC_LANES-1:0] checker_align_pulse_o,
  output wire [`SLBC_LANES-1:0] counting_enabled_o
);

  // Base of this MAC instance; the whole map shifts with it
  localparam [`SLBC_ADR_W-1:0] MAC_OFF =
    `SLBC_MAC_STRIDE * {16'h0000, MAC_INDEX};

  // Matches a word address against one register of this instance
  function hit;
    input [`SLBC_ADR_W-1:0] adr;
    input [`SLBC_ADR_W-1:0] off;
    begin
      hit = (adr[`SLBC_ADR_W-1:2] == off[`SLBC_ADR_W-1:2]);
    end
  endfunction

  // Byte offset of counter register k (0 or 1) of a lane
  function [`SLBC_ADR_W-1:0] cnt_off;
    input integer lane;
    input integer k;
    begin
      cnt_off = MAC_OFF + `SLBC_L0_CNT0_OFF
        + `SLBC_LANE_STRIDE * lane[`SLBC_ADR_W-1:0]
        + (k[0] ? 18'h00004 : 18'h00000);
    end
  endfunction

  reg ack_reg;
  reg [31:0] dat_reg;
  reg [31:0] dat_next;
  wire req;
  wire wr;
  wire ctrl_hit;
  reg [`SLBC_LANES*`SLBC_PAT_W-1:0] pat_reg;
  reg [`SLBC_LANES-1:0] start_reg;
  reg [`SLBC_LANES-1:0] freeze_reg;
  reg [`SLBC_LANES-1:0] armed_reg;
  reg [`SLBC_LANES-1:0] align_reg;
  reg [`SLBC_LANES-1:0] en_reg;
  wire [`SLBC_LANES*`SLBC_GRP_W-1:0] grp_all;
  wire [`SLBC_LANES*`SLBC_ERR_W-1:0] err_all;
  wire [`SLBC_LANES-1:0] hit0;
  wire [`SLBC_LANES-1:0] hit1;
  integer i;

  // A request is taken on the first edge with cyc and stb and no ack
  assign req = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign wr = req & wb_we_i;
  assign ctrl_hit = hit(wb_adr_i, MAC_OFF + `SLBC_CTRL_OFF);

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
  assign pattern_sel_o = pat_reg;
  assign generator_release_o = start_reg;
  assign checker_align_pulse_o = align_reg;
  assign counting_enabled_o = en_reg;

  // Single-wait-state ack; it drops the cycle after it is given
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h00000000;
    end else begin
      ack_reg <= req;
      if (req & ~wb_we_i) begin
        dat_reg <= dat_next;
      end
    end
  end

  // Read mux; unmapped words and reserved bits read as zero
  always @* begin
    dat_next = 32'h00000000;
    if (ctrl_hit) begin
      for (i = 0; i < `SLBC_LANES; i = i + 1) begin
        // Align and clear are pulses and always read back zero
        dat_next[i*`SLBC_LANE_BITS+`SLBC_F_PAT_LO +: `SLBC_PAT_W] =
          pat_reg[i*`SLBC_PAT_W +: `SLBC_PAT_W];
        dat_next[i*`SLBC_LANE_BITS+`SLBC_F_START] = start_reg[i];
        dat_next[i*`SLBC_LANE_BITS+`SLBC_F_FREEZE] = freeze_reg[i];
      end
    end
    for (i = 0; i < `SLBC_LANES; i = i + 1) begin
      if (hit0[i]) begin
        dat_next = {grp_all[i*`SLBC_GRP_W+32 +: `SLBC_GRP_HI_W],
                    err_all[i*`SLBC_ERR_W +: `SLBC_ERR_W]};
      end
      if (hit1[i]) begin
        dat_next = grp_all[i*`SLBC_GRP_W +: 32];
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < `SLBC_LANES; g = g + 1) begin : lane
      // Lane g owns one byte lane of the control word
      localparam integer B = g * `SLBC_LANE_BITS;
      wire byte_wr;
      wire wr_clear;
      wire wr_align;
      wire wr_freeze;
      wire freeze_nxt;
      wire cnt0_zero;
      wire cnt1_zero;
      reg [2:0] align_cnt_reg;
      reg [`SLBC_GRP_W-1:0] grp_reg;
      reg [`SLBC_ERR_W-1:0] err_reg;

      assign hit0[g] = hit(wb_adr_i, cnt_off(g, 0));
      assign hit1[g] = hit(wb_adr_i, cnt_off(g, 1));
      assign byte_wr = wr & ctrl_hit & wb_sel_i[g];
      assign wr_clear = byte_wr & wb_dat_i[B+`SLBC_F_CLEAR];
      assign wr_align = byte_wr & wb_dat_i[B+`SLBC_F_ALIGN];
      assign wr_freeze = byte_wr & wb_dat_i[B+`SLBC_F_FREEZE];
      // Freeze value that holds after this edge, so enable sees the write
      assign freeze_nxt = byte_wr ? wb_dat_i[B+`SLBC_F_FREEZE]
                                  : freeze_reg[g];
      // An all-zero write to a counter word clears what it holds
      assign cnt0_zero = wr & hit0[g] & (wb_dat_i == 32'h00000000);
      assign cnt1_zero = wr & hit1[g] & (wb_dat_i == 32'h00000000);
      assign grp_all[g*`SLBC_GRP_W +: `SLBC_GRP_W] = grp_reg;
      assign err_all[g*`SLBC_ERR_W +: `SLBC_ERR_W] = err_reg;

      // Stored control fields; reserved codes are kept as written
      always @(posedge clk_i) begin
        if (rst_i) begin
          pat_reg[g*`SLBC_PAT_W +: `SLBC_PAT_W] <= `SLBC_PAT_OFF;
          start_reg[g] <= 1'b0;
          freeze_reg[g] <= 1'b0;
        end else if (byte_wr) begin
          pat_reg[g*`SLBC_PAT_W +: `SLBC_PAT_W] <=
            wb_dat_i[B+`SLBC_F_PAT_LO +: `SLBC_PAT_W];
          start_reg[g] <= wb_dat_i[B+`SLBC_F_START];
          freeze_reg[g] <= wb_dat_i[B+`SLBC_F_FREEZE];
        end
      end

      // Alignment request: high on the write edge plus three more
      always @(posedge clk_i) begin
        if (rst_i) begin
          align_cnt_reg <= 3'h0;
          align_reg[g] <= 1'b0;
        end else if (wr_align) begin
          align_cnt_reg <= `SLBC_ALIGN_RELOAD;
          align_reg[g] <= 1'b1;
        end else if (align_cnt_reg != 3'h0) begin
          align_cnt_reg <= align_cnt_reg - 3'h1;
          align_reg[g] <= 1'b1;
        end else begin
          align_reg[g] <= 1'b0;
        end
      end

      // An align written while frozen does not arm, so a stale checker
      // never counts after the next unfreeze
      always @(posedge clk_i) begin
        if (rst_i) begin
          armed_reg[g] <= 1'b0;
          en_reg[g] <= 1'b0;
        end else begin
          if (wr_align) begin
            armed_reg[g] <= ~freeze_nxt;
          end else if (wr_freeze) begin
            armed_reg[g] <= 1'b0;
          end
          en_reg[g] <= (armed_reg[g] | wr_align) & ~freeze_nxt;
        end
      end

      // Counters; a clear in the same cycle beats an increment
      always @(posedge clk_i) begin
        if (rst_i) begin
          grp_reg <= {`SLBC_GRP_W{1'b0}};
          err_reg <= {`SLBC_ERR_W{1'b0}};
        end else if (wr_clear) begin
          grp_reg <= {`SLBC_GRP_W{1'b0}};
          err_reg <= {`SLBC_ERR_W{1'b0}};
        end else begin
          if (cnt0_zero) begin
            grp_reg[`SLBC_GRP_W-1:32] <= {`SLBC_GRP_HI_W{1'b0}};
            err_reg <= {`SLBC_ERR_W{1'b0}};
          end else if (en_reg[g] & code_group_valid_i[g]
                       & code_group_error_i[g]) begin
            err_reg <= err_reg + 16'h0001;
          end
          if (cnt1_zero) begin
            grp_reg[31:0] <= 32'h00000000;
          end else if (en_reg[g] & code_group_valid_i[g]
                       & ~cnt0_zero) begin
            grp_reg <= grp_reg + 48'h000000000001;
          end
        end
      end
    end
  endgenerate

endmodule

// >>> test/slbc_lane_src.sv
// Far lane end model feeding received code groups to all four lanes
`timescale 1ns/1ps
module slbc_lane_src (
  input wire logic run_i,
  input wire logic [3:0] err_i,
  output logic [3:0] valid_o,
  output logic [3:0] error_o
);
  // One group per cycle while running; idle error line holds the inverse of err_i
  assign valid_o = {4{run_i}};
  assign error_o = run_i ? err_i : ~err_i;
endmodule

// >>> test/slbc_monitor.sv
// Port assertions for the lane test control and counter block
`timescale 1ns/1ps
`include "slbc_defs.vh"
module slbc_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [17:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire logic [11:0] pattern_sel_o,
  input wire logic [3:0] generator_release_o,
  input wire logic [3:0] checker_align_pulse_o,
  input wire logic [3:0] counting_enabled_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Lane 0 control write taken at this edge, and its align request
  wire take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wr0 = take && wb_we_i && wb_adr_i == `SLBC_CTRL_OFF && wb_sel_i[0];
  wire al0 = wr0 && wb_dat_i[2];
  sequence s_pulse;
    checker_align_pulse_o[0] [*4] ##1 !checker_align_pulse_o[0];
  endsequence
  property p_ack; take |=> wb_ack_o; endproperty
  property p_ack1; wb_ack_o |=> !wb_ack_o; endproperty
  property p_align; al0 |=> s_pulse; endproperty
  property p_acause; $rose(checker_align_pulse_o[0]) |-> $past(al0);
  endproperty
  // Enable follows the taking edge of the control write
  property p_arm; al0 && !wb_dat_i[1] |=> counting_enabled_o[0];
  endproperty
  property p_ecause; $rose(counting_enabled_o[0]) |-> $past(al0) ||
    $past(al0, 2); endproperty
  property p_frz; wr0 && wb_dat_i[1] |=> !counting_enabled_o[0];
  endproperty
  property p_pat; wr0 |=> pattern_sel_o[2:0] == $past(wb_dat_i[6:4]);
  endproperty
  property p_rel; wr0 |=> generator_release_o[0] == $past(wb_dat_i[3]);
  endproperty
  a_ack: assert property (p_ack) else $error("ack missing");
  a_ack1: assert property (p_ack1) else $error("ack too long");
  a_align: assert property (p_align)
    else $error("align pulse length wrong");
  a_acause: assert property (p_acause)
    else $error("align pulse without write");
  a_arm: assert property (p_arm)
    else $error("counting not enabled");
  a_ecause: assert property (p_ecause)
    else $error("counting enabled without align");
  a_frz: assert property (p_frz)
    else $error("freeze ignored");
  a_pat: assert property (p_pat)
    else $error("pattern select wrong");
  a_rel: assert property (p_rel)
    else $error("generator release wrong");
endmodule
bind slbc_top slbc_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_ack_o(wb_ack_o), .pattern_sel_o(pattern_sel_o),
  .generator_release_o(generator_release_o),
  .checker_align_pulse_o(checker_align_pulse_o),
  .counting_enabled_o(counting_enabled_o));

// >>> test/tb.sv
// Register level testbench for the lane test block
`timescale 1ns/1ps
`include "slbc_defs.vh"
module tb;
  localparam logic [17:0] CT = `SLBC_CTRL_OFF;
  localparam logic [17:0] C0 = `SLBC_L0_CNT0_OFF;
  localparam logic [17:0] C1 = `SLBC_L0_CNT1_OFF;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack, go = 0;
  logic [17:0] adr = 0;
  logic [31:0] dw = 0, dr, rd;
  logic [3:0] er = 0, vld, err, rel;
  logic [11:0] pat;
  int n_fail = 0, total_checks = 0;
  slbc_top u_slbc_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack),
    .code_group_valid_i(vld), .code_group_error_i(err),
    .pattern_sel_o(pat), .generator_release_o(rel),
    .checker_align_pulse_o(), .counting_enabled_o());
  slbc_lane_src u_slbc_lane_src (.run_i(go), .err_i(er), .valid_o(vld),
    .error_o(err));
  initial forever #2.5 clk_i = ~clk_i;
  // Single Wishbone cycle; request held until ack is sampled
  task wb(input logic w, input logic [17:0] a, input logic [31:0] d);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dw <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    rd = dr;
    cyc <= 1'b0; stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task rc(input logic [17:0] a, input logic [31:0] e);
    wb(1'b0, a, 0);
    chk(rd, e);
  endtask
  // Exactly n received groups, each flagged bad when e is set
  task run(input int n, input logic e);
    go <= 1'b1; er <= {4{e}};
    repeat (n) @(posedge clk_i);
    go <= 1'b0;
    @(posedge clk_i);
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Whole run is about a hundred cycles; this cuts a hang short
  initial begin
    #20000;
    n_fail++;
    complete_run;
  end
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rc(CT, 0);
    rc(C0, 0);
    rc(C1, 0);
    wb(1'b1, CT, 32'h08402810);
    rc(CT, 32'h08402810);
    chk({20'h0, pat}, 32'h111);
    chk({28'h0, rel}, 32'hA);
    run(5, 1'b0);
    rc(C1, 0);
    $display("field test done");
    wb(1'b1, CT, 32'h1C);
    rc(CT, 32'h18);
    run(6, 1'b0);
    run(4, 1'b1);
    wb(1'b1, CT, 32'h1A);
    run(3, 1'b1);
    rc(C1, 32'hA);
    rc(C0, 32'h4);
    $display("count test done");
    wb(1'b1, C1, 0);
    rc(C1, 0);
    rc(C0, 32'h4);
    wb(1'b1, C0, 0);
    rc(C0, 0);
    wb(1'b1, CT, 32'h1C);
    run(3, 1'b1);
    wb(1'b1, CT, 32'h1B);
    rc(C1, 0);
    rc(C0, 0);
    rc(CT, 32'h1A);
    rc(18'h13000, 0);
    $display("clear test done");
    complete_run;
  end
endmodule
